/* File: include/sysctl_pkg.sv */
// package for the system control upper field block
// assumes a single 40 MHz clock and an Avalon-MM register slave
`default_nettype none
package sysctl_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0]  SYSCTL_ADDR_CONFIG   = 4'h0;
    localparam logic [3:0]  SYSCTL_ADDR_IRQ_STAT = 4'h4;
    localparam logic [3:0]  SYSCTL_ADDR_IRQ_EN   = 4'h8;
    localparam logic [3:0]  SYSCTL_ADDR_IRQ_CLR  = 4'hC;
    localparam logic [3:0]  SYSCTL_ADDR_PWR_WR   = 4'h0;
    localparam logic [3:0]  SYSCTL_ADDR_SOCK_SEL = 4'h0;
    // ************************************************************
    // field positions in the config word
    // ************************************************************
    localparam int          SYSCTL_BIT_STEP_HI   = 31;
    localparam int          SYSCTL_BIT_STEP_LO   = 30;
    localparam int          SYSCTL_BIT_TIE       = 29;
    localparam int          SYSCTL_BIT_RSVD28    = 28;
    localparam int          SYSCTL_BIT_OSC       = 27;
    localparam int          SYSCTL_BIT_ROUTE     = 26;
    localparam int          SYSCTL_BIT_FLAG      = 25;
    localparam int          SYSCTL_BIT_EN        = 24;
    localparam int          SYSCTL_BIT_RSVD23    = 23;
    localparam int          SYSCTL_BIT_SPARE     = 22;
    localparam int          SYSCTL_BIT_PROT      = 21;
    localparam int          SYSCTL_BIT_SOCKET    = 0;
    // ************************************************************
    // reset values and constant values
    // ************************************************************
    localparam logic [1:0]  SYSCTL_RST_STEP      = 2'h0;
    localparam logic        SYSCTL_RST_TIE       = 1'h0;
    localparam logic        SYSCTL_RST_ROUTE     = 1'h0;
    localparam logic        SYSCTL_RST_EN        = 1'h0;
    localparam logic        SYSCTL_RST_SPARE     = 1'h1;
    localparam logic        SYSCTL_RST_PROT      = 1'h0;
    localparam logic        SYSCTL_OSC_VALUE     = 1'h1;
    localparam logic [1:0]  SYSCTL_IRQ_W         = 2'h2;
    // ************************************************************
    // slave state machine
    // ************************************************************
    typedef enum logic [1:0] {
        SYSCTL_ST_IDLE = 2'b01,
        SYSCTL_ST_ACK  = 2'b10
    } sysctl_state_t;
endpackage : sysctl_pkg
`default_nettype wire

/* File: verilog/sysctl_upper.sv */
// system control upper fields (bits 31..21) with Avalon-MM slave
// assumes synchronous bus master; pins are synchronised to clk_in here
`default_nettype none
module sysctl_upper
    import sysctl_pkg::*;
#(
    parameter int SOCKETS = 2
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                arst_n_in,
    // avalon-mm slave
    input  wire logic [3:0]          avs_address_in,
    input  wire logic                avs_read_in,
    input  wire logic                avs_write_in,
    input  wire logic [31:0]         avs_writedata_in,
    input  wire logic [3:0]          avs_byteenable_in,
    output logic [31:0]              avs_readdata_out,
    output logic                     avs_waitrequest_out,
    // socket selection for per-socket fields
    input  wire logic                sock_sel_in,
    // socket power write events and card presence
    input  wire logic [SOCKETS-1:0]  pwr_write_in,
    input  wire logic [SOCKETS-1:0]  cb_card_in,
    // raw interrupt inputs a and b
    input  wire logic                irq_a_in,
    input  wire logic                irq_b_in,
    // interrupt slot mapping a..d
    output logic [3:0]               serial_slot_out,
    output logic                     pin_reg_tie_out,
    // power write interrupt routing
    output logic                     legacy_irq_line_2_out,
    output logic [SOCKETS-1:0]       card_status_change_irq_out,
    // spare cardbus terminals
    output logic [SOCKETS-1:0]       spare_pin_out,
    output logic [SOCKETS-1:0]       spare_pin_oe_out,
    // supply protection
    output logic [SOCKETS-1:0]       supply_protect_on_out,
    // block interrupt
    output logic                     irq_out
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [SOCKETS-1:0] pwr_meta, pwr_sync, pwr_last;
    logic [SOCKETS-1:0] card_meta, card_sync;
    logic [1:0]         irq_meta, irq_sync;

    // two flops on every pin input
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pwr_meta  <= '0;
            pwr_sync  <= '0;
            pwr_last  <= '0;
            card_meta <= '0;
            card_sync <= '0;
            irq_meta  <= '0;
            irq_sync  <= '0;
        end else begin
            pwr_meta  <= pwr_write_in;
            pwr_sync  <= pwr_meta;
            pwr_last  <= pwr_sync;
            card_meta <= cb_card_in;
            card_sync <= card_meta;
            irq_meta  <= {irq_b_in, irq_a_in};
            irq_sync  <= irq_meta;
        end
    end

    // ************************************************************
    // register state
    // ************************************************************
    logic [1:0]         step;
    logic               tie;
    logic               route;
    logic               smi_en;
    logic               spare;
    logic [SOCKETS-1:0] prot_off;
    logic [SOCKETS-1:0] flag;
    logic [1:0]         irq_stat;
    logic [1:0]         irq_en;
    sysctl_state_t      state;
    sysctl_state_t      next_state;

    // ************************************************************
    // bus decode
    // ************************************************************
    wire                wr_cfg   = avs_write_in && state == SYSCTL_ST_ACK
                                   && avs_address_in == SYSCTL_ADDR_CONFIG;
    wire                wr_en    = avs_write_in && state == SYSCTL_ST_ACK
                                   && avs_address_in == SYSCTL_ADDR_IRQ_EN;
    wire                wr_clr   = avs_write_in && state == SYSCTL_ST_ACK
                                   && avs_address_in == SYSCTL_ADDR_IRQ_CLR;
    wire                be3      = avs_byteenable_in[3];
    wire                be2      = avs_byteenable_in[2];
    wire                be0      = avs_byteenable_in[0];
    wire [SOCKETS-1:0]  sel_mask = SOCKETS'(1) << sock_sel_in;
    wire [SOCKETS-1:0]  pwr_evt  = pwr_sync & ~pwr_last;
    wire [SOCKETS-1:0]  flag_set = smi_en ? pwr_evt : '0;
    wire [SOCKETS-1:0]  flag_clr = (wr_cfg && be3 && avs_writedata_in[SYSCTL_BIT_FLAG])
                                   ? sel_mask : '0;
    wire [1:0]          evt      = {|(flag_set & ~flag), |flag_set};
    wire [1:0]          stat_clr = (wr_clr && be0) ? avs_writedata_in[1:0] : 2'h0;

    // one wait cycle then acknowledge
    assign next_state = (state == SYSCTL_ST_IDLE && (avs_read_in || avs_write_in))
                        ? SYSCTL_ST_ACK : SYSCTL_ST_IDLE;
    assign avs_waitrequest_out = (avs_read_in || avs_write_in) && state != SYSCTL_ST_ACK;

    // bus handshake state
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= SYSCTL_ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // config word
    // ************************************************************
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            step     <= SYSCTL_RST_STEP;
            tie      <= SYSCTL_RST_TIE;
            route    <= SYSCTL_RST_ROUTE;
            smi_en   <= SYSCTL_RST_EN;
            spare    <= SYSCTL_RST_SPARE;
            prot_off <= {SOCKETS{SYSCTL_RST_PROT}};
        end else if (wr_cfg) begin
            if (be3) begin
                step   <= avs_writedata_in[SYSCTL_BIT_STEP_HI:SYSCTL_BIT_STEP_LO];
                tie    <= avs_writedata_in[SYSCTL_BIT_TIE];
                route  <= avs_writedata_in[SYSCTL_BIT_ROUTE];
                smi_en <= avs_writedata_in[SYSCTL_BIT_EN];
            end
            if (be2) begin
                spare    <= avs_writedata_in[SYSCTL_BIT_SPARE];
                prot_off <= avs_writedata_in[SYSCTL_BIT_PROT] ? (prot_off | sel_mask)
                                                              : (prot_off & ~sel_mask);
            end
        end
    end

    // sticky flags; a set in the same cycle beats the clear
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            flag     <= '0;
            irq_stat <= 2'h0;
            irq_en   <= 2'h0;
        end else begin
            flag     <= (flag & ~flag_clr) | flag_set;
            irq_stat <= (irq_stat & ~stat_clr) | evt;
            if (wr_en && be0) begin
                irq_en <= avs_writedata_in[1:0];
            end
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    wire [31:0] cfg_word = {step, tie, 1'b0, SYSCTL_OSC_VALUE, route,
                            flag[sock_sel_in], smi_en, 1'b0, spare,
                            prot_off[sock_sel_in], 21'h0};
    wire [31:0] rd_mux   = (avs_address_in == SYSCTL_ADDR_CONFIG)   ? cfg_word :
                           (avs_address_in == SYSCTL_ADDR_IRQ_STAT) ? {30'h0, irq_stat} :
                           (avs_address_in == SYSCTL_ADDR_IRQ_EN)   ? {30'h0, irq_en} :
                                                                     32'h0;

    // read data registered on the waiting cycle
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            avs_readdata_out <= 32'h0;
        end else if (avs_read_in && state == SYSCTL_ST_IDLE) begin
            avs_readdata_out <= rd_mux;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    wire        irq_b_eff = tie ? 1'b0 : irq_sync[1];
    wire        irq_a_eff = irq_sync[0] | (tie & irq_sync[1]);
    wire [3:0]  slot_raw  = {2'b00, irq_b_eff, irq_a_eff};

    // rotate a/b into the chosen slot pair
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            serial_slot_out <= 4'h0;
        end else begin
            serial_slot_out <= 4'((slot_raw << step) | (slot_raw >> (3'd4 - {1'b0, step})));
        end
    end

    assign pin_reg_tie_out            = tie;
    assign legacy_irq_line_2_out      = ~route & (|flag);
    assign card_status_change_irq_out = route ? flag : '0;
    assign spare_pin_out              = '0;
    assign spare_pin_oe_out           = spare ? card_sync : '0;
    assign supply_protect_on_out      = ~prot_off;
    assign irq_out                    = |(irq_stat & irq_en);
endmodule : sysctl_upper
`default_nettype wire

/* File: verification/sysctl_upper_props.sv */
// checker: bus timing and output relations of sysctl_upper
// assumes binding to the design top, sees its ports only
`default_nettype none
module sysctl_upper_props #(parameter int SOCKETS = 2) (
    // clock and reset
    input wire logic               clk_in,
    input wire logic               arst_n_in,
    // register bus
    input wire logic [3:0]         avs_address_in,
    input wire logic               avs_read_in,
    input wire logic               avs_write_in,
    input wire logic [31:0]        avs_readdata_out,
    input wire logic               avs_waitrequest_out,
    // socket side
    input wire logic [SOCKETS-1:0] cb_card_in,
    input wire logic [3:0]         serial_slot_out,
    input wire logic               pin_reg_tie_out,
    input wire logic               legacy_irq_line_2_out,
    input wire logic [SOCKETS-1:0] card_status_change_irq_out,
    input wire logic [SOCKETS-1:0] spare_pin_out,
    input wire logic [SOCKETS-1:0] spare_pin_oe_out,
    input wire logic [SOCKETS-1:0] supply_protect_on_out,
    input wire logic               irq_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    // a transfer completes in the cycle waitrequest is low
    wire logic req  = avs_read_in | avs_write_in;
    wire logic done = req & !avs_waitrequest_out;
    wait_first_a: assert property ($rose(req) |-> avs_waitrequest_out) else $error("no wait");
    wait_one_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("wait too long");
    fixed_bits_a: assert property (done && avs_read_in && avs_address_in == 4'h0 |->
        avs_readdata_out[28:27] == 2'h1 && !avs_readdata_out[23]) else $error("fixed bits");
    spare_drive_a: assert property ((spare_pin_oe_out & ~cb_card_in) == '0
        && spare_pin_out == '0) else $error("spare pins");
    route_excl_a: assert property (!(legacy_irq_line_2_out && |card_status_change_irq_out))
        else $error("route");
    tie_change_a: assert property ($changed(pin_reg_tie_out) |-> $past(done && avs_write_in))
        else $error("tie");
    prot_change_a: assert property ($changed(supply_protect_on_out) |->
        $past(done && avs_write_in)) else $error("protect");
    slot_count_a: assert property ($countones(serial_slot_out) <= 2) else $error("slots");
    cover property ($rose(irq_out));
    cover property ($rose(legacy_irq_line_2_out));
    cover property ($rose(|card_status_change_irq_out));
endmodule : sysctl_upper_props
bind sysctl_upper sysctl_upper_props #(.SOCKETS(SOCKETS)) sysctl_upper_props_i (.*);
`default_nettype wire

/* File: verification/sysctl_socket_model.sv */
// socket side model: power writes and card presence
// assumes requests from the bench on clk_in
`default_nettype none
module sysctl_socket_model (
    // requests
    input wire logic       clk_in,
    input wire logic [1:0] pulse_in,
    input wire logic [1:0] card_in,
    // socket pins
    output logic [1:0]     pwr_write_out,
    output logic [1:0]     cb_card_out
);
    int unsigned hold [2] = '{0, 0}; // known idle level from time zero, no x on the pins
    // a power write is a level held four clocks, then released
    always_ff @(posedge clk_in) begin
        for (int s = 0; s < 2; s++) begin
            if (pulse_in[s]) hold[s] <= 4;
            else if (hold[s] != 0) hold[s] <= hold[s] - 1;
        end
    end
    assign pwr_write_out = {hold[1] != 0, hold[0] != 0};
    assign cb_card_out = card_in;
endmodule : sysctl_socket_model
`default_nettype wire

/* File: verification/sysctl_upper_test.sv */
// bench for sysctl_upper: register model, socket model, checker
// assumes one 40 MHz clock and an active-low asynchronous reset
`default_nettype none
module sysctl_upper_test import sysctl_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_in = 0, arst_n_in = 0, rd = 0, wr = 0, sel = 0, wq, tie, leg, irq;
    logic [3:0] adr = 0, be = 4'hF, slot;
    logic [31:0] wd = 0, rdata, rq, d, shared = 32'h00400000;
    logic [1:0] pulse = 0, ab = 2'h3, pw, cbc, card_status_change_irq, sp, oe, prot;
    int fail_count = 0, checks_done = 0, flag [2] = '{0, 0}, prm [2] = '{0, 0};
    sysctl_socket_model sysctl_socket_model_i (.clk_in(clk_in), .pulse_in(pulse),
        .card_in(2'h1), .pwr_write_out(pw), .cb_card_out(cbc));
    sysctl_upper #(.SOCKETS(2)) sysctl_upper_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wq),
        .sock_sel_in(sel), .pwr_write_in(pw), .cb_card_in(cbc), .irq_a_in(ab[0]),
        .irq_b_in(ab[1]), .serial_slot_out(slot), .pin_reg_tie_out(tie),
        .legacy_irq_line_2_out(leg), .card_status_change_irq_out(card_status_change_irq), .spare_pin_out(sp),
        .spare_pin_oe_out(oe), .supply_protect_on_out(prot), .irq_out(irq));
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one bus transfer, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dt);
        int n;
        @(posedge clk_in);
        wr <= w; rd <= !w; adr <= a; wd <= dt;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_in);
            if (!wq) break;
        end
        rq = rdata;
        wr <= 0; rd <= 0;
        // let registered outputs settle before the caller compares them
        repeat (2) @(posedge clk_in);
        if (n == 20) begin
            fail_count++;
            wrap_up();
        end
    endtask : bus
    task automatic wcfg(input int s, input logic [31:0] dt);
        sel <= s[0];
        bus(1, SYSCTL_ADDR_CONFIG, dt);
        shared = dt & 32'hE5400000;
        prm[s] = dt[21];
        if (dt[25]) flag[s] = 0;
    endtask : wcfg
    task automatic rcfg(input int s);
        sel <= s[0];
        bus(0, SYSCTL_ADDR_CONFIG, 0);
        chk(rq & 32'hFFE00000, shared | 32'h08000000 | flag[s] << 25 | prm[s] << 21);
    endtask : rcfg
    task automatic evt(input int s);
        @(posedge clk_in);
        pulse <= 2'h1 << s;
        @(posedge clk_in);
        pulse <= 0;
        repeat (10) @(posedge clk_in);
        if (shared[24]) flag[s] = 1;
    endtask : evt
    initial begin
        void'($urandom(85985));
        repeat (16) @(posedge clk_in);
        arst_n_in <= 1;
        chk(prot, 2'h3);
        rcfg(0);
        for (int k = 0; k < 4; k++) begin
            d = ($urandom() & 32'h3FFFFFFF) | (k << 30);
            wcfg(k % 2, d);
            rcfg(k % 2);
            chk(tie, d[29]);
            chk(slot, (4'h1 << k) | (d[29] ? 4'h0 : 4'h1 << ((k + 1) % 4)));
            chk(prot, {!prm[1], !prm[0]});
            chk(oe, {1'b0, d[22]});
        end
        wcfg(0, 32'h05400000);
        evt(0);
        rcfg(0);
        chk({card_status_change_irq, leg}, 3'h2);
        wcfg(0, 32'h01400000);
        rcfg(0);
        chk({card_status_change_irq, leg}, 3'h1);
        bus(0, SYSCTL_ADDR_IRQ_STAT, 0);
        chk(rq[0], 1);
        bus(1, SYSCTL_ADDR_IRQ_EN, 32'h1);
        chk(irq, 1);
        bus(1, SYSCTL_ADDR_IRQ_CLR, 32'h1);
        chk(irq, 0);
        wcfg(0, 32'h03400000);
        rcfg(0);
        chk(leg, 0);
        evt(1);
        rcfg(1);
        bus(1, 4'h2, $urandom());
        bus(0, 4'h2, 0);
        chk(rq, 0);
        chk(sp, 0);
        wrap_up();
    end
endmodule : sysctl_upper_test
`default_nettype wire
